//--- dtr_pkg.sv
// Operation
// R1 - timebase internal or external, shared A/D-D/A
// R2 - external timebase stays 1 to 40 MHz
// R3 - two trigger pins, edge chosen by software
// R4 - aux zero rising edge starts conversion
// R5 - aux zero strobe disables interval, scan generator
// R6 - aux zero strobe disables trigger settings
// R7 - aux zero scan pulse exceeds two timebases
// R8 - aux zero serves one function only
// R9 - aux one rising edge replaces update strobe
// R10 - bus line: one master, three slaves
// R11 - each signal master, slave or disabled
// R12 - role chosen separately per signal
// R13 - timebase master drives, slave uses bus
// R14 - trigger master drives, slave accepts bus
// R15 - strobes driven as master, used as slave
// R16 - software routes six signals onto bus
// R17 - reset selects internal sources, no mastering
// R18 - scan start aligned to selected timebase
// R19 - strobes synchronised, edge made single pulse
// R20 - line released unless master
`default_nettype none
package dtr_pkg;
  localparam int ADDR_W         = 4;
  localparam int NSIG           = 6;
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_SYNC   = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
  localparam logic [31:0] SYNC_RST  = 32'h0000_0000;
  localparam int CTRL_TB_EXT    = 0;
  localparam int CTRL_AD_FALL   = 1;
  localparam int CTRL_DA_FALL   = 2;
  localparam int CTRL_AUX0_LSB  = 3;
  localparam int CTRL_AUX1_EN   = 5;
  localparam int ST_TB_LVL      = 0;
  localparam int ST_TB_SRC_LSB  = 1;
  localparam int ST_AUX0_CONV   = 3;
  localparam int ST_AUX0_SCAN   = 4;
  localparam int ST_CONV_LSB    = 8;
  localparam int SYS_PERIOD_NS  = 100;
  localparam int BUS_PULSE_NS   = 300;
  localparam int BUS_PULSE_CYC  = (BUS_PULSE_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam int TB_INT_HALF_CYC = 2;
  localparam int SIG_TB   = 0;
  localparam int SIG_ADTR = 1;
  localparam int SIG_CONV = 2;
  localparam int SIG_SCAN = 3;
  localparam int SIG_DATR = 4;
  localparam int SIG_UPD  = 5;
  typedef enum logic [1:0] {ROLE_OFF, ROLE_MASTER, ROLE_SLAVE, ROLE_RSVD} dtr_role_t;
  typedef enum logic [1:0] {AUX0_NONE, AUX0_CONV, AUX0_SCAN, AUX0_RSVD} dtr_aux0_t;
  typedef enum logic [1:0] {TBS_INT, TBS_EXT, TBS_BUS, TBS_RSVD} dtr_tbsrc_t;
endpackage
`default_nettype wire

//--- dtr_sync_bus_if.sv
`timescale 1ns/10ps
`default_nettype none
interface dtr_sync_bus_if;
  logic [5:0] dev_out;
  logic [5:0] dev_oe;
  logic [5:0] far_out;
  logic [5:0] far_oe;
  logic [5:0] line;
  // resolved lines, pulled low when nobody drives
  assign line = (dev_out & dev_oe) | (far_out & far_oe);
  modport dev (output dev_out, output dev_oe, input line);
  modport far (output far_out, output far_oe, input line);
endinterface
`default_nettype wire

//--- dtr_edge_sync.sv
`timescale 1ns/10ps
`default_nettype none
module dtr_edge_sync (
  // clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_srst,
  // async input and edge choice
  input  wire logic i_async,
  input  wire logic i_fall,
  // filtered level and edge pulse
  output logic      o_level,
  output logic      o_pulse
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic lvl_nxt;

  always_ff @(posedge i_clk_sys) begin
    s1_r <= i_async;
    s2_r <= s1_r;
    s3_r <= s2_r;
  end

  // R19 accept when agree
  assign lvl_nxt = (s2_r == s3_r) ? s3_r : o_level;

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_level <= 1'b0;
      o_pulse <= 1'b0;
    end else begin
      o_level <= lvl_nxt;
      // R19 single edge pulse
      o_pulse <= (lvl_nxt != o_level) && (lvl_nxt == !i_fall);
    end
  end
endmodule
`default_nettype wire

//--- dtr_device_end.sv
`timescale 1ns/10ps
`default_nettype none
module dtr_device_end #(
  parameter int unsigned TB_HALF_CYC = dtr_pkg::TB_INT_HALF_CYC
) (
  // clock and reset
  input  wire logic                       i_clk_sys,
  input  wire logic                       i_srst,
  // register port
  input  wire logic [dtr_pkg::ADDR_W-1:0] i_reg_addr,
  input  wire logic [31:0]                i_reg_wdata,
  input  wire logic                       i_reg_wr,
  input  wire logic                       i_reg_rd,
  output logic      [31:0]                o_reg_rdata,
  // pins
  input  wire logic                       i_external_clock_in,
  input  wire logic                       i_ad_ext_trigger_in,
  input  wire logic                       i_da_ext_trigger_in,
  input  wire logic                       i_aux_input_zero,
  input  wire logic                       i_aux_input_one,
  // internal generator pulses
  input  wire logic                       i_gen_ad_trigger,
  input  wire logic                       i_gen_da_trigger,
  input  wire logic                       i_gen_scan_begin,
  input  wire logic                       i_gen_conv_strobe,
  input  wire logic                       i_gen_update_strobe,
  // routed timing signals
  output logic                            o_tb_level,
  output logic                            o_tb_tick,
  output logic                            o_ad_trigger,
  output logic                            o_da_trigger,
  output logic                            o_scan_begin,
  output logic                            o_conv_strobe,
  output logic                            o_update_strobe,
  output logic                            o_interval_cnt_en,
  output logic                            o_trig_settings_en,
  // sync bus
  dtr_sync_bus_if.dev                     bus
);
  import dtr_pkg::*;

  localparam int NIN = 5 + NSIG;

  if (TB_HALF_CYC < 1 || TB_HALF_CYC > 255) begin : g_chk
    $error("TB_HALF_CYC out of range");
  end

  logic [31:0]     ctrl_r;
  logic [31:0]     sync_r;
  logic [NIN-1:0]  in_vec;
  logic [NIN-1:0]  fall_vec;
  logic [NIN-1:0]  lvl;
  logic [NIN-1:0]  pls;
  logic [7:0]      div_r;
  logic            int_tb_r;
  logic            tb_nxt;
  dtr_tbsrc_t      tb_src;
  dtr_aux0_t       aux0_mode;
  logic            aux0_tb_r;
  logic            scan_pend_r;
  logic [7:0]      conv_cnt_r;
  logic            ad_loc;
  logic            da_loc;
  logic            conv_loc;
  logic            scan_loc;
  logic            upd_loc;
  logic [5:0]      loc_pls;
  logic [1:0]      str_r [1:NSIG-1];

  function automatic dtr_role_t role_of(input logic [31:0] cfg, input int idx);
    role_of = dtr_role_t'(cfg[2*idx +: 2]);
  endfunction

  function automatic logic is_slave(input logic [31:0] cfg, input int idx);
    is_slave = (role_of(cfg, idx) == ROLE_SLAVE);
  endfunction

  // R3 R19 pin and line synchronisers
  assign in_vec   = {bus.line, i_aux_input_one, i_aux_input_zero,
                     i_da_ext_trigger_in, i_ad_ext_trigger_in, i_external_clock_in};
  assign fall_vec = {{NSIG{1'b0}}, 2'b00, ctrl_r[CTRL_DA_FALL], ctrl_r[CTRL_AD_FALL], 1'b0};

  for (genvar g = 0; g < NIN; g++) begin : g_sync
    dtr_edge_sync u_sync (
      .i_clk_sys (i_clk_sys),
      .i_srst    (i_srst),
      .i_async   (in_vec[g]),
      .i_fall    (fall_vec[g]),
      .o_level   (lvl[g]),
      .o_pulse   (pls[g])
    );
  end

  // R16 R17 register writes
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      ctrl_r <= CTRL_RST;
      sync_r <= SYNC_RST;
    end else if (i_reg_wr) begin
      if (i_reg_addr == REG_CTRL) begin
        ctrl_r <= i_reg_wdata;
      end
      if (i_reg_addr == REG_SYNC) begin
        sync_r <= i_reg_wdata;
      end
    end
  end

  // register reads
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_reg_rdata <= 32'h0000_0000;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        REG_CTRL:   o_reg_rdata <= {26'h0, ctrl_r[5:0]};
        REG_SYNC:   o_reg_rdata <= {20'h0, sync_r[11:0]};
        REG_STATUS: o_reg_rdata <= {16'h0, conv_cnt_r, 3'h0,
                                    aux0_mode == AUX0_SCAN, aux0_mode == AUX0_CONV,
                                    tb_src, o_tb_level};
        default:    o_reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      o_reg_rdata <= 32'h0000_0000;
    end
  end

  // internal timebase divider
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      div_r    <= 8'h00;
      int_tb_r <= 1'b0;
    end else if (div_r == 8'(TB_HALF_CYC - 1)) begin
      div_r    <= 8'h00;
      int_tb_r <= ~int_tb_r;
    end else begin
      div_r <= div_r + 8'h01;
    end
  end

  // R1 R13 timebase source
  always_comb begin
    if (is_slave(sync_r, SIG_TB)) begin
      tb_src = TBS_BUS;
      tb_nxt = lvl[5 + SIG_TB];
    end else if (ctrl_r[CTRL_TB_EXT]) begin
      tb_src = TBS_EXT;
      tb_nxt = lvl[0];
    end else begin
      tb_src = TBS_INT;
      tb_nxt = int_tb_r;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_tb_level <= 1'b0;
      o_tb_tick  <= 1'b0;
    end else begin
      o_tb_level <= tb_nxt;
      o_tb_tick  <= tb_nxt & ~o_tb_level;
    end
  end

  // R8 one aux zero function
  always_comb begin
    case (ctrl_r[CTRL_AUX0_LSB +: 2])
      2'h1:    aux0_mode = AUX0_CONV;
      2'h2:    aux0_mode = AUX0_SCAN;
      default: aux0_mode = AUX0_NONE;
    endcase
  end

  // R5 R6 external strobe mode
  assign o_interval_cnt_en  = (aux0_mode != AUX0_CONV);
  assign o_trig_settings_en = (aux0_mode != AUX0_CONV);

  // R18 R7 scan on timebase ticks
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      aux0_tb_r   <= 1'b0;
      scan_pend_r <= 1'b0;
    end else begin
      if (o_tb_tick) begin
        aux0_tb_r <= lvl[3];
      end
      if (i_gen_scan_begin && aux0_mode == AUX0_NONE && !o_tb_tick) begin
        scan_pend_r <= 1'b1;
      end else if (o_tb_tick || aux0_mode != AUX0_NONE) begin
        scan_pend_r <= 1'b0;
      end
    end
  end

  // R3 R6 R14 local triggers
  assign ad_loc = o_trig_settings_en & (pls[1] | i_gen_ad_trigger);
  assign da_loc = pls[2] | i_gen_da_trigger;
  // R4 aux zero conversion
  assign conv_loc = (aux0_mode == AUX0_CONV) ? pls[3] : i_gen_conv_strobe;
  // R5 R18 scan source
  always_comb begin
    case (aux0_mode)
      AUX0_SCAN: scan_loc = o_tb_tick & lvl[3] & ~aux0_tb_r;
      AUX0_CONV: scan_loc = 1'b0;
      default:   scan_loc = o_tb_tick & (scan_pend_r | i_gen_scan_begin);
    endcase
  end
  // R9 aux one update
  assign upd_loc = ctrl_r[CTRL_AUX1_EN] ? pls[4] : i_gen_update_strobe;

  assign loc_pls = {upd_loc, da_loc, scan_loc, conv_loc, ad_loc, 1'b0};

  // R14 R15 slave takes bus pulse
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_ad_trigger    <= 1'b0;
      o_da_trigger    <= 1'b0;
      o_conv_strobe   <= 1'b0;
      o_scan_begin    <= 1'b0;
      o_update_strobe <= 1'b0;
    end else begin
      // R6 no A/D trigger in strobe mode
      o_ad_trigger    <= o_trig_settings_en &
                         (is_slave(sync_r, SIG_ADTR) ? pls[5 + SIG_ADTR] : ad_loc);
      o_da_trigger    <= is_slave(sync_r, SIG_DATR) ? pls[5 + SIG_DATR] : da_loc;
      o_conv_strobe   <= is_slave(sync_r, SIG_CONV) ? pls[5 + SIG_CONV] : conv_loc;
      o_scan_begin    <= is_slave(sync_r, SIG_SCAN) ? pls[5 + SIG_SCAN] : scan_loc;
      o_update_strobe <= is_slave(sync_r, SIG_UPD)  ? pls[5 + SIG_UPD]  : upd_loc;
    end
  end

  // conversion count for status
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      conv_cnt_r <= 8'h00;
    end else if (o_conv_strobe) begin
      conv_cnt_r <= conv_cnt_r + 8'h01;
    end
  end

  // R15 stretch pulses for the line
  always_ff @(posedge i_clk_sys) begin
    for (int k = 1; k < NSIG; k++) begin
      if (i_srst) begin
        str_r[k] <= 2'h0;
      end else if (loc_pls[k]) begin
        str_r[k] <= 2'(BUS_PULSE_CYC);
      end else if (str_r[k] != 2'h0) begin
        str_r[k] <= str_r[k] - 2'h1;
      end
    end
  end

  // R10 R11 R12 R20 per-signal drive
  always_comb begin
    for (int k = 0; k < NSIG; k++) begin
      bus.dev_oe[k] = (role_of(sync_r, k) == ROLE_MASTER);
    end
  end

  // R13 R14 R15 master line data
  always_comb begin
    bus.dev_out[0] = o_tb_level;
    for (int k = 1; k < NSIG; k++) begin
      bus.dev_out[k] = (str_r[k] != 2'h0);
    end
  end
endmodule
`default_nettype wire

//--- dtr_far_end.sv
`timescale 1ns/10ps
`default_nettype none
module dtr_far_end #(
  parameter int unsigned TB_HALF_CYC = dtr_pkg::TB_INT_HALF_CYC
) (
  // clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_srst,
  // roles, two bits per signal
  input  wire logic [11:0] i_role_cfg,
  // pulses to send as master
  input  wire logic [5:1]  i_send_pulse,
  // received signals
  output logic             o_rx_tb_level,
  output logic [5:1]       o_rx_pulse,
  // sync bus
  dtr_sync_bus_if.far      bus
);
  import dtr_pkg::*;

  if (TB_HALF_CYC < 1 || TB_HALF_CYC > 255) begin : g_chk
    $error("TB_HALF_CYC out of range");
  end

  logic [NSIG-1:0] lvl;
  logic [NSIG-1:0] pls;
  logic [7:0]      div_r;
  logic            tb_r;
  logic [1:0]      str_r [1:NSIG-1];

  for (genvar g = 0; g < NSIG; g++) begin : g_sync
    dtr_edge_sync u_sync (
      .i_clk_sys (i_clk_sys),
      .i_srst    (i_srst),
      .i_async   (bus.line[g]),
      .i_fall    (1'b0),
      .o_level   (lvl[g]),
      .o_pulse   (pls[g])
    );
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      div_r <= 8'h00;
      tb_r  <= 1'b0;
    end else if (div_r == 8'(TB_HALF_CYC - 1)) begin
      div_r <= 8'h00;
      tb_r  <= ~tb_r;
    end else begin
      div_r <= div_r + 8'h01;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    for (int k = 1; k < NSIG; k++) begin
      if (i_srst) begin
        str_r[k] <= 2'h0;
      end else if (i_send_pulse[k]) begin
        str_r[k] <= 2'(BUS_PULSE_CYC);
      end else if (str_r[k] != 2'h0) begin
        str_r[k] <= str_r[k] - 2'h1;
      end
    end
  end

  // R10 R11 R20 master drives only
  always_comb begin
    bus.far_out[0] = tb_r;
    bus.far_oe[0]  = (i_role_cfg[1:0] == ROLE_MASTER);
    for (int k = 1; k < NSIG; k++) begin
      bus.far_out[k] = (str_r[k] != 2'h0);
      bus.far_oe[k]  = (i_role_cfg[2*k +: 2] == ROLE_MASTER);
    end
  end

  // R11 slave receives
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_rx_tb_level <= 1'b0;
      o_rx_pulse    <= 5'h00;
    end else begin
      o_rx_tb_level <= (i_role_cfg[1:0] == ROLE_SLAVE) & lvl[0];
      for (int k = 1; k < NSIG; k++) begin
        o_rx_pulse[k] <= (i_role_cfg[2*k +: 2] == ROLE_SLAVE) & pls[k];
      end
    end
  end
endmodule
`default_nettype wire

//--- dtr_bus_props.sv
`timescale 1ns/10ps
`default_nettype none
module dtr_bus_props (
  // clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_srst,
  // bus signals
  input  wire logic [5:0] dev_out,
  input  wire logic [5:0] dev_oe,
  input  wire logic [5:0] far_out,
  input  wire logic [5:0] far_oe
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);

  chk_reset_quiet:
    assert property ($fell(i_srst) |-> (dev_oe == 6'h00) && (far_oe == 6'h00))
    else $error("bus driven right after reset");
  chk_one_master:
    assert property ((dev_oe & far_oe) == 6'h00)
    else $error("both ends drive one line");
  chk_conv_stretch:
    assert property ($rose(dev_out[2] && dev_oe[2]) |-> (dev_out[2] && dev_oe[2])[*3] ##1 !dev_out[2])
    else $error("conversion strobe drive not three cycles");
  chk_scan_stretch:
    assert property ($rose(dev_out[3] && dev_oe[3]) |-> (dev_out[3] && dev_oe[3])[*3] ##1 !dev_out[3])
    else $error("scan begin drive not three cycles");
  chk_datrig_stretch:
    assert property ($rose(dev_out[4] && dev_oe[4]) |-> (dev_out[4] && dev_oe[4])[*3] ##1 !dev_out[4])
    else $error("output trigger drive not three cycles");
  chk_update_stretch:
    assert property ($rose(dev_out[5] && dev_oe[5]) |-> (dev_out[5] && dev_oe[5])[*3] ##1 !dev_out[5])
    else $error("update strobe drive not three cycles");
  chk_far_trig:
    assert property ($rose(far_out[1] && far_oe[1]) |-> (far_out[1] && far_oe[1])[*3] ##1 !far_out[1])
    else $error("far trigger drive not three cycles");
  chk_tb_hold:
    assert property (dev_oe[0] && $past(dev_oe[0]) && $changed(dev_out[0]) |=> !dev_oe[0] || $stable(dev_out[0]))
    else $error("driven timebase toggles too fast");
endmodule
`default_nettype wire

//--- daq_timing_source_router_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`define DTR_CHK(a, b) begin checked++; if ((a) !== (b)) begin error_cnt++; $display("[FAIL] %0t got %0h exp %0h", $time, (a), (b)); end end
module daq_timing_source_router_tb_top;
  import dtr_pkg::*;
  logic        clk, srst, wr, rd, ext_clk, ext_run, tb_level, tb_tick, cnt_en, trg_en;
  logic        rx_tb, rx_tb_q;
  logic [3:0]  addr, pin;
  logic [31:0] wdata, rdata, d;
  logic [9:0]  pl;
  logic [11:0] far_role;
  wire  [4:0]  dout;
  logic [5:1]  rx_pulse;
  int          error_cnt, checked, seed, k, t0, r0, ticks, rises;
  int          cnt_dev[5], exp_dev[5], cnt_far[6], exp_far[6];
  int          sig_of[5] = '{1, 4, 3, 2, 5};

  dtr_sync_bus_if i_dtr_sync_bus_if ();
  dtr_device_end #(.TB_HALF_CYC(2)) i_dtr_device_end (
    .i_clk_sys(clk), .i_srst(srst), .i_reg_addr(addr), .i_reg_wdata(wdata),
    .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .i_external_clock_in(ext_clk),
    .i_ad_ext_trigger_in(pin[0]), .i_da_ext_trigger_in(pin[1]), .i_aux_input_zero(pin[2]),
    .i_aux_input_one(pin[3]), .i_gen_ad_trigger(pl[0]), .i_gen_da_trigger(pl[1]),
    .i_gen_scan_begin(pl[2]), .i_gen_conv_strobe(pl[3]), .i_gen_update_strobe(pl[4]),
    .o_tb_level(tb_level), .o_tb_tick(tb_tick), .o_ad_trigger(dout[0]),
    .o_da_trigger(dout[1]), .o_scan_begin(dout[2]), .o_conv_strobe(dout[3]),
    .o_update_strobe(dout[4]), .o_interval_cnt_en(cnt_en), .o_trig_settings_en(trg_en),
    .bus(i_dtr_sync_bus_if.dev));
  dtr_far_end #(.TB_HALF_CYC(2)) i_dtr_far_end (
    .i_clk_sys(clk), .i_srst(srst), .i_role_cfg(far_role), .i_send_pulse(pl[9:5]),
    .o_rx_tb_level(rx_tb), .o_rx_pulse(rx_pulse), .bus(i_dtr_sync_bus_if.far));
  dtr_bus_props i_dtr_bus_props (
    .i_clk_sys(clk), .i_srst(srst), .dev_out(i_dtr_sync_bus_if.dev_out),
    .dev_oe(i_dtr_sync_bus_if.dev_oe), .far_out(i_dtr_sync_bus_if.far_out),
    .far_oe(i_dtr_sync_bus_if.far_oe));

  // pulse and edge counters
  always @(posedge clk) begin
    for (int i = 0; i < 5; i++) if (dout[i] === 1'b1) cnt_dev[i]++;
    for (int i = 1; i < 6; i++) if (rx_pulse[i] === 1'b1) cnt_far[i]++;
    if (tb_tick === 1'b1) ticks++;
    if (rx_tb === 1'b1 && rx_tb_q === 1'b0) rises++;
    rx_tb_q <= rx_tb;
  end

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic pulse(input int n);
    @(posedge clk);
    pl[n] <= 1'b1;
    @(posedge clk);
    pl[n] <= 1'b0;
    repeat (10) @(posedge clk);
  endtask
  task automatic step(input int n, input logic v);
    @(posedge clk);
    pin[n] <= v;
    repeat (10) @(posedge clk);
  endtask
  task automatic chk_counts;
    for (int i = 0; i < 5; i++) `DTR_CHK(cnt_dev[i], exp_dev[i])
    for (int i = 1; i < 6; i++) `DTR_CHK(cnt_far[i], exp_far[i])
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    #37;
    forever begin
      #400;
      ext_clk = ext_run ? ~ext_clk : 1'b0;
    end
  end
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    give_verdict();
  end

  initial begin
    srst = 1'b1; addr = '0; wdata = '0; wr = 1'b0; rd = 1'b0; ext_clk = 1'b0;
    ext_run = 1'b0; pin = '0; pl = '0; far_role = '0; seed = 43; error_cnt = 0;
    checked = 0; ticks = 0; rises = 0; rx_tb_q = 1'b0;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    wr_reg(4'hC, 32'hFFFF_FFFF);
    rd_reg(REG_CTRL);
    `DTR_CHK(d, CTRL_RST)
    rd_reg(REG_SYNC);
    `DTR_CHK(d, SYNC_RST)
    rd_reg(4'hC);
    `DTR_CHK(d, 32'h0)
    `DTR_CHK({cnt_en, trg_en, i_dtr_sync_bus_if.dev_oe}, 8'hC0)
    $display("test 1 done");
    repeat (8) begin
      k = $unsigned($random(seed)) % 5;
      pulse(k);
      exp_dev[k]++;
    end
    chk_counts();
    $display("test 2 done");
    for (int p = 0; p < 2; p++) begin
      wr_reg(REG_CTRL, 32'(p * 6));
      for (int j = 0; j < 2; j++) begin
        step(j, 1'b1);
        exp_dev[j] += 1 - p;
        chk_counts();
        step(j, 1'b0);
        exp_dev[j] += p;
        chk_counts();
      end
    end
    $display("test 3 done");
    wr_reg(REG_CTRL, 32'h0000_0008);
    rd_reg(REG_STATUS);
    `DTR_CHK({cnt_en, trg_en, d[4:3]}, 4'h1)
    step(2, 1'b1);
    exp_dev[3]++;
    chk_counts();
    step(2, 1'b0);
    step(0, 1'b1);
    step(0, 1'b0);
    pulse(3);
    pulse(2);
    chk_counts();
    wr_reg(REG_CTRL, 32'h0000_0010);
    step(2, 1'b1);
    exp_dev[2]++;
    chk_counts();
    step(2, 1'b0);
    `DTR_CHK(cnt_en, 1'b1)
    $display("test 4 done");
    wr_reg(REG_CTRL, 32'h0000_0020);
    step(3, 1'b1);
    exp_dev[4]++;
    chk_counts();
    pulse(4);
    step(3, 1'b0);
    chk_counts();
    $display("test 5 done");
    wr_reg(REG_CTRL, 32'h0);
    far_role <= 12'hAA4;
    wr_reg(REG_SYNC, 32'h0000_0558);
    for (int r = 0; r < 8; r++) begin
      k = (r < 4) ? r + 1 : 1 + $unsigned($random(seed)) % 4;
      pulse(k);
      exp_dev[k]++;
      exp_far[sig_of[k]]++;
    end
    pulse(5);
    exp_dev[0]++;
    step(0, 1'b1);
    step(0, 1'b0);
    chk_counts();
    `DTR_CHK(i_dtr_sync_bus_if.dev_oe[1:0], 2'b00)
    $display("test 6 done");
    far_role <= 12'h000;
    wr_reg(REG_SYNC, 32'h1);
    far_role <= 12'h002;
    #1 t0 = ticks;
    repeat (40) @(posedge clk);
    #1 `DTR_CHK(ticks - t0, 10)
    ext_run = 1'b1;
    wr_reg(REG_SYNC, 32'h0);
    wr_reg(REG_CTRL, 32'h1);
    wr_reg(REG_SYNC, 32'h1);
    repeat (20) @(posedge clk);
    rd_reg(REG_STATUS);
    `DTR_CHK(d[2:1], 2'h1)
    `DTR_CHK(d[15:8], 8'(exp_dev[3]))
    #1 t0 = ticks;
    r0 = rises;
    repeat (80) @(posedge clk);
    #1 `DTR_CHK((rises - r0 >= 9) && (rises - r0 <= 11), 1'b1)
    `DTR_CHK((ticks - t0 >= 9) && (ticks - t0 <= 11), 1'b1)
    wr_reg(REG_SYNC, 32'h0);
    far_role <= 12'h001;
    wr_reg(REG_SYNC, 32'h2);
    ext_run = 1'b0;
    repeat (20) @(posedge clk);
    rd_reg(REG_STATUS);
    `DTR_CHK(d[2:1], 2'h2)
    #1 t0 = ticks;
    repeat (40) @(posedge clk);
    #1 `DTR_CHK((ticks - t0 >= 9) && (ticks - t0 <= 11), 1'b1)
    $display("test 7 done");
    far_role <= 12'h000;
    @(posedge clk);
    srst <= 1'b1;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    rd_reg(REG_SYNC);
    `DTR_CHK(d, SYNC_RST)
    rd_reg(REG_STATUS);
    `DTR_CHK(d[15:1], 15'h0)
    $display("test 8 done");
    give_verdict();
  end
endmodule
`default_nettype wire
